/* sam_pkg.sv */
// constants, types and register map of the split address output block
// assumes the peripheral bus gives a 12-bit offset inside the peripheral i/o area
// Notes on behaviour
// - mode register takes 8-bit writes only; reads return a fixed, non-stored value
// - mode register bits 3 to 7 always zero; low three bits select size
// - size codes 010..111 add address bits A1-A4 up to A15; 000 is port mode
// - address bits only go to port 3 pins 4-6, port 10 all, port 11 pins 0-3
// - the mode register alone does not switch pins; emulator enable also needed
// - after reset port 10 direction reads ff and port 11 direction reads 1f
// - address normally leaves multiplexed with data; split output is optional
// - wait pin shares the A1 pin, so pin wait is lost while A1 is split
package sam_pkg;
	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [31:0] SAM_OFF_P3_LATCH = 32'hFFFF_F006;
	localparam logic [31:0] SAM_OFF_P10_LATCH = 32'hFFFF_F014;
	localparam logic [31:0] SAM_OFF_P11_LATCH = 32'hFFFF_F016;
	localparam logic [31:0] SAM_OFF_P3_DIR = 32'hFFFF_F026;
	localparam logic [31:0] SAM_OFF_P10_DIR = 32'hFFFF_F034;
	localparam logic [31:0] SAM_OFF_P11_DIR = 32'hFFFF_F036;
	localparam logic [31:0] SAM_OFF_EXP_MODE = 32'hFFFF_F04C;
	localparam logic [31:0] SAM_OFF_SPLIT_MODE = 32'hFFFF_F068;
	// --------------------------------------------------------------
	// reset values and fixed read values
	// --------------------------------------------------------------
	localparam logic [7:0] SAM_RST_LATCH = 8'h00;
	localparam logic [7:0] SAM_RST_P3_DIR = 8'hFF;
	localparam logic [7:0] SAM_RST_P10_DIR = 8'hFF;
	localparam logic [7:0] SAM_RST_P11_DIR = 8'h1F;
	localparam logic [3:0] SAM_RST_EXP_MODE = 4'h0;
	localparam logic [2:0] SAM_RST_SPLIT_MODE = 3'h0;
	localparam logic [7:0] SAM_SPLIT_READ_VAL = 8'h00;
	localparam logic [7:0] SAM_UNUSED_HIGH = 8'h00;
	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int SAM_EXP_MODE_W = 4;
	localparam int SAM_SPLIT_SIZE_W = 3;
	localparam int SAM_WAIT_PIN = 0;
	localparam int SAM_P3_ADDR_LO = 4;
	localparam int SAM_P3_ADDR_HI = 6;
	// --------------------------------------------------------------
	// split size codes and expansion codes
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		SAM_SIZE_PORT = 3'b000,
		SAM_SIZE_RSV = 3'b001,
		SAM_SIZE_32B = 3'b010,
		SAM_SIZE_512B = 3'b011,
		SAM_SIZE_8K = 3'b100,
		SAM_SIZE_16K = 3'b101,
		SAM_SIZE_32K = 3'b110,
		SAM_SIZE_64K = 3'b111
	} sam_size_t;
	localparam logic [2:0] SAM_EXP_64K = 3'b011;
	localparam logic [3:0] SAM_SPAN_0 = 4'h0;
	localparam logic [3:0] SAM_SPAN_32B = 4'h4;
	localparam logic [3:0] SAM_SPAN_512B = 4'h8;
	localparam logic [3:0] SAM_SPAN_8K = 4'hC;
	localparam logic [3:0] SAM_SPAN_16K = 4'hD;
	localparam logic [3:0] SAM_SPAN_32K = 4'hE;
	localparam logic [3:0] SAM_SPAN_64K = 4'hF;
endpackage : sam_pkg

/* sam_port_if.sv */
// signals between the register side and one 8-bit port pin cell
// assumes one instance per port, all on clk_sys_i
`timescale 1ns/10ps
interface sam_port_if;
	logic [7:0] latch;
	logic [7:0] dir;
	logic [7:0] addr_sel;
	logic [7:0] addr_val;
	logic [7:0] level;
	modport ctrl_mp (output latch, output dir, output addr_sel, output addr_val, input level);
	modport pin_mp (input latch, input dir, input addr_sel, input addr_val, output level);
endinterface : sam_port_if

/* sam_port.sv */
// one 8-bit port: pin drive, address override and pin input synchroniser
// assumes pin inputs are asynchronous to clk_sys_i
`timescale 1ns/10ps
module sam_port
	import sam_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	sam_port_if.pin_mp port,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_n_o
);
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [7:0] sync3_reg;
	logic [7:0] level_reg;
	logic [7:0] level_next;
	logic [7:0] out_reg;
	logic [7:0] out_next;
	logic [7:0] oe_n_reg;
	logic [7:0] oe_n_next;

	// --------------------------------------------------------------
	// per-pin selection
	// --------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_pin
			// assigned pins carry the bus address, others the port latch
			assign out_next[b] = port.addr_sel[b] ? port.addr_val[b] : port.latch[b];
			assign oe_n_next[b] = port.addr_sel[b] ? 1'b0 : port.dir[b];
			// change taken once second and third stages agree
			assign level_next[b] = (sync2_reg[b] == sync3_reg[b]) ? sync3_reg[b] : level_reg[b];
		end
	endgenerate

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			sync3_reg <= 8'h00;
			level_reg <= 8'h00;
			out_reg <= 8'h00;
			oe_n_reg <= 8'hFF;
		end else begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign port.level = level_reg;
	assign pin_o = out_reg;
	assign pin_oe_n_o = oe_n_reg;
endmodule : sam_port

/* sam_top.sv */
// split address output block: port latches, directions, mode registers
// assumes byte or halfword accesses on the peripheral i/o bus, same clock
`timescale 1ns/10ps
module sam_top
	import sam_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [11:0] per_addr_i,
	input wire logic per_wr_i,
	input wire logic per_rd_i,
	input wire logic per_hword_i,
	input wire logic [15:0] per_wdata_i,
	output logic [15:0] per_rdata_o,
	output logic per_rvalid_o,
	input wire logic [15:1] ext_addr_i,
	input wire logic emu_split_en_i,
	output logic [3:0] expansion_mode_o,
	output logic split_active_o,
	output logic ext_wait_req_o,
	input wire logic [7:0] p3_pin_i,
	output logic [7:0] p3_pin_o,
	output logic [7:0] p3_pin_oe_n_o,
	input wire logic [7:0] p10_pin_i,
	output logic [7:0] p10_pin_o,
	output logic [7:0] p10_pin_oe_n_o,
	input wire logic [7:0] p11_pin_i,
	output logic [7:0] p11_pin_o,
	output logic [7:0] p11_pin_oe_n_o
);
	// --------------------------------------------------------------
	// register state
	// --------------------------------------------------------------
	logic [7:0] p3_latch_reg;
	logic [7:0] p3_latch_next;
	logic [7:0] p10_latch_reg;
	logic [7:0] p10_latch_next;
	logic [7:0] p11_latch_reg;
	logic [7:0] p11_latch_next;
	logic [7:0] p3_dir_reg;
	logic [7:0] p3_dir_next;
	logic [7:0] p10_dir_reg;
	logic [7:0] p10_dir_next;
	logic [7:0] p11_dir_reg;
	logic [7:0] p11_dir_next;
	logic [3:0] exp_mode_reg;
	logic [3:0] exp_mode_next;
	logic [2:0] split_mode_reg;
	logic [2:0] split_mode_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic emu_s1_reg;
	logic emu_s2_reg;
	logic emu_s3_reg;
	logic emu_en_reg;
	logic emu_en_next;

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	wire hit_p3_latch = per_addr_i[11:1] == SAM_OFF_P3_LATCH[11:1];
	wire hit_p10_latch = per_addr_i[11:1] == SAM_OFF_P10_LATCH[11:1];
	wire hit_p11_latch = per_addr_i[11:1] == SAM_OFF_P11_LATCH[11:1];
	wire hit_p3_dir = per_addr_i[11:1] == SAM_OFF_P3_DIR[11:1];
	wire hit_p10_dir = per_addr_i[11:1] == SAM_OFF_P10_DIR[11:1];
	wire hit_p11_dir = per_addr_i[11:1] == SAM_OFF_P11_DIR[11:1];
	wire hit_exp_mode = per_addr_i[11:1] == SAM_OFF_EXP_MODE[11:1];
	wire hit_split_mode = per_addr_i[11:1] == SAM_OFF_SPLIT_MODE[11:1];
	wire [7:0] wbyte = per_wdata_i[7:0];

	wire wr_p3_latch = per_wr_i && hit_p3_latch;
	wire wr_p10_latch = per_wr_i && hit_p10_latch;
	wire wr_p11_latch = per_wr_i && hit_p11_latch;
	wire wr_p3_dir = per_wr_i && hit_p3_dir;
	wire wr_p10_dir = per_wr_i && hit_p10_dir;
	wire wr_p11_dir = per_wr_i && hit_p11_dir;
	wire wr_exp_mode = per_wr_i && hit_exp_mode;
	// halfword writes to the mode register are dropped
	wire wr_split_mode = per_wr_i && hit_split_mode && !per_hword_i;

	// --------------------------------------------------------------
	// next register values
	// --------------------------------------------------------------
	assign p3_latch_next = wr_p3_latch ? wbyte : p3_latch_reg;
	assign p10_latch_next = wr_p10_latch ? wbyte : p10_latch_reg;
	assign p11_latch_next = wr_p11_latch ? wbyte : p11_latch_reg;
	assign p3_dir_next = wr_p3_dir ? wbyte : p3_dir_reg;
	assign p10_dir_next = wr_p10_dir ? wbyte : p10_dir_reg;
	assign p11_dir_next = wr_p11_dir ? wbyte : p11_dir_reg;
	assign exp_mode_next = wr_exp_mode ? wbyte[SAM_EXP_MODE_W-1:0] : exp_mode_reg;
	// only the size field is kept, upper bits stay zero
	assign split_mode_next = wr_split_mode ? wbyte[SAM_SPLIT_SIZE_W-1:0] : split_mode_reg;

	// --------------------------------------------------------------
	// emulator enable synchroniser
	// --------------------------------------------------------------
	assign emu_en_next = (emu_s2_reg == emu_s3_reg) ? emu_s3_reg : emu_en_reg;

	// --------------------------------------------------------------
	// split address selection
	// --------------------------------------------------------------
	sam_size_t size_code;
	assign size_code = sam_size_t'(split_mode_reg);

	// external expansion must be on for any split output
	wire exp_on = exp_mode_reg[2:0] >= SAM_EXP_64K;

	// the mode register needs the emulator enable too
	// default stays multiplexed, split only when selected
	// reserved code 001 takes no pins, so it counts as port mode
	wire size_ok = (size_code != SAM_SIZE_PORT) && (size_code != SAM_SIZE_RSV);
	wire split_on = exp_on && emu_en_reg && size_ok;

	// number of address bits that take over pins
	wire [3:0] span_w = !split_on ? SAM_SPAN_0 :
		(size_code == SAM_SIZE_32B) ? SAM_SPAN_32B :
		(size_code == SAM_SIZE_512B) ? SAM_SPAN_512B :
		(size_code == SAM_SIZE_8K) ? SAM_SPAN_8K :
		(size_code == SAM_SIZE_16K) ? SAM_SPAN_16K :
		(size_code == SAM_SIZE_32K) ? SAM_SPAN_32K :
		(size_code == SAM_SIZE_64K) ? SAM_SPAN_64K : SAM_SPAN_0;

	// mask bit i stands for address bit A(i+1)
	logic [14:0] addr_mask;
	genvar i;
	generate
		for (i = 0; i < 15; i++) begin : g_mask
			assign addr_mask[i] = 4'(i) < span_w;
		end
	endgenerate

	// --------------------------------------------------------------
	// port connections
	// --------------------------------------------------------------
	sam_port_if p3_if ();
	sam_port_if p10_if ();
	sam_port_if p11_if ();

	assign p3_if.latch = p3_latch_reg;
	assign p3_if.dir = p3_dir_reg;
	assign p10_if.latch = p10_latch_reg;
	assign p10_if.dir = p10_dir_reg;
	assign p11_if.latch = p11_latch_reg;
	assign p11_if.dir = p11_dir_reg;

	// address bits reach only the listed pins
	assign p11_if.addr_sel = {4'h0, addr_mask[3:0]};
	assign p11_if.addr_val = {4'h0, ext_addr_i[4:1]};
	assign p10_if.addr_sel = addr_mask[11:4];
	assign p10_if.addr_val = ext_addr_i[12:5];
	assign p3_if.addr_sel = {1'b0, addr_mask[14:12], 4'h0};
	assign p3_if.addr_val = {1'b0, ext_addr_i[15:13], 4'h0};

	sam_port u_port3 (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.port(p3_if.pin_mp),
		.pin_i(p3_pin_i),
		.pin_o(p3_pin_o),
		.pin_oe_n_o(p3_pin_oe_n_o)
	);

	sam_port u_port10 (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.port(p10_if.pin_mp),
		.pin_i(p10_pin_i),
		.pin_o(p10_pin_o),
		.pin_oe_n_o(p10_pin_oe_n_o)
	);

	sam_port u_port11 (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.port(p11_if.pin_mp),
		.pin_i(p11_pin_i),
		.pin_o(p11_pin_o),
		.pin_oe_n_o(p11_pin_oe_n_o)
	);

	// --------------------------------------------------------------
	// wait pin sharing
	// --------------------------------------------------------------
	// pin wait is blocked while A1 owns the shared pin
	wire wait_pin_free = !addr_mask[SAM_WAIT_PIN];
	wire wait_level_n = p11_if.level[SAM_WAIT_PIN];
	wire ext_wait_next = wait_pin_free && p11_dir_reg[SAM_WAIT_PIN] && !wait_level_n;
	logic ext_wait_reg;

	// --------------------------------------------------------------
	// read path
	// --------------------------------------------------------------
	// input pins read their level, output pins their latch
	wire [7:0] p3_read = (p3_dir_reg & p3_if.level) | (~p3_dir_reg & p3_latch_reg);
	wire [7:0] p10_read = (p10_dir_reg & p10_if.level) | (~p10_dir_reg & p10_latch_reg);
	wire [7:0] p11_read = (p11_dir_reg & p11_if.level) | (~p11_dir_reg & p11_latch_reg);
	logic [7:0] rbyte;
	always_comb begin
		if (hit_p3_latch) begin
			rbyte = p3_read;
		end else if (hit_p10_latch) begin
			rbyte = p10_read;
		end else if (hit_p11_latch) begin
			rbyte = p11_read;
		end else if (hit_p3_dir) begin
			rbyte = p3_dir_reg;
		end else if (hit_p10_dir) begin
			rbyte = p10_dir_reg;
		end else if (hit_p11_dir) begin
			rbyte = p11_dir_reg;
		end else if (hit_exp_mode) begin
			rbyte = {4'h0, exp_mode_reg};
		end else if (hit_split_mode) begin
			rbyte = SAM_SPLIT_READ_VAL;
		end else begin
			rbyte = 8'h00;
		end
	end
	assign rdata_next = per_rd_i ? {SAM_UNUSED_HIGH, rbyte} : rdata_reg;
	assign rvalid_next = per_rd_i;

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			p3_latch_reg <= SAM_RST_LATCH;
			p10_latch_reg <= SAM_RST_LATCH;
			p11_latch_reg <= SAM_RST_LATCH;
		end else begin
			p3_latch_reg <= p3_latch_next;
			p10_latch_reg <= p10_latch_next;
			p11_latch_reg <= p11_latch_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			p3_dir_reg <= SAM_RST_P3_DIR;
			p10_dir_reg <= SAM_RST_P10_DIR;
			p11_dir_reg <= SAM_RST_P11_DIR;
		end else begin
			p3_dir_reg <= p3_dir_next;
			p10_dir_reg <= p10_dir_next;
			p11_dir_reg <= p11_dir_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			exp_mode_reg <= SAM_RST_EXP_MODE;
			split_mode_reg <= SAM_RST_SPLIT_MODE;
		end else begin
			exp_mode_reg <= exp_mode_next;
			split_mode_reg <= split_mode_next;
		end
	end

	// --------------------------------------------------------------
	// read answer and wait request
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 16'h0000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_wait_reg <= 1'b0;
		end else begin
			ext_wait_reg <= ext_wait_next;
		end
	end

	// --------------------------------------------------------------
	// emulator enable registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			emu_s1_reg <= 1'b0;
			emu_s2_reg <= 1'b0;
			emu_s3_reg <= 1'b0;
		end else begin
			emu_s1_reg <= emu_split_en_i;
			emu_s2_reg <= emu_s1_reg;
			emu_s3_reg <= emu_s2_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			emu_en_reg <= 1'b0;
		end else begin
			emu_en_reg <= emu_en_next;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign per_rdata_o = rdata_reg;
	assign per_rvalid_o = rvalid_reg;
	assign expansion_mode_o = exp_mode_reg;
	assign split_active_o = split_on;
	assign ext_wait_req_o = ext_wait_reg;
endmodule : sam_top

/* sam_top_assertions.sv */
// checker for the split address output block
// assumes binding to sam_top, seeing only its ports
`timescale 1ns/10ps
module sam_top_assertions
	import sam_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic [11:0] per_addr_i,
	input wire logic per_wr_i,
	input wire logic per_rd_i,
	input wire logic [15:0] per_wdata_i,
	input wire logic [15:0] per_rdata_o,
	input wire logic per_rvalid_o,
	input wire logic [15:1] ext_addr_i,
	input wire logic emu_split_en_i,
	input wire logic [3:0] expansion_mode_o,
	input wire logic split_active_o,
	input wire logic ext_wait_req_o,
	input wire logic [7:0] p11_pin_o,
	input wire logic [7:0] p11_pin_oe_n_o,
	input wire logic [7:0] p3_pin_oe_n_o
);
	// ----
	// helpers
	// ----
	wire logic [3:0] wd_lo = per_wdata_i[3:0];
	wire logic a1 = ext_addr_i[1];
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// ----
	// properties
	// ----
	property p_rd_answer;
		per_rd_i |=> per_rvalid_o && per_rdata_o[15:8] == 8'h00;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rd_hold;
		!per_rd_i |=> !per_rvalid_o && $stable(per_rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_split_read;
		per_rd_i && per_addr_i[11:1] == SAM_OFF_SPLIT_MODE[11:1] |=> per_rdata_o == 16'h0000;
	endproperty
	a_split_read: assert property (p_split_read) else $error("mode read not fixed");
	property p_exp_wr;
		per_wr_i && per_addr_i[11:1] == SAM_OFF_EXP_MODE[11:1] |=> expansion_mode_o == $past(wd_lo);
	endproperty
	a_exp_wr: assert property (p_exp_wr) else $error("expansion mode not stored");
	property p_emu_gate;
		!emu_split_en_i [*5] |-> !split_active_o;
	endproperty
	a_emu_gate: assert property (p_emu_gate) else $error("split without emulator");
	property p_a1_out;
		split_active_o |=> !p11_pin_oe_n_o[0] && p11_pin_o[0] == $past(a1);
	endproperty
	a_a1_out: assert property (p_a1_out) else $error("A1 not on pin");
	property p_wait_lost;
		split_active_o |=> !ext_wait_req_o;
	endproperty
	a_wait_lost: assert property (p_wait_lost) else $error("pin wait while split");
	property p_fixed_pins;
		$rose(split_active_o) && !per_wr_i && !$past(per_wr_i)
			|=> $stable(p11_pin_oe_n_o[7:4]) && $stable(p3_pin_oe_n_o[3:0]);
	endproperty
	a_fixed_pins: assert property (p_fixed_pins) else $error("non address pin moved");
endmodule : sam_top_assertions

bind sam_top sam_top_assertions chk_u (.*);

/* sam_ext_dev.sv */
// far side: external device pins and the address it sees
// assumes undriven pins take the level given by the bench
`timescale 1ns/10ps
module sam_ext_dev (
	input wire logic [7:0] p3_o_i,
	input wire logic [7:0] p3_oe_n_i,
	input wire logic [7:0] p10_o_i,
	input wire logic [7:0] p10_oe_n_i,
	input wire logic [7:0] p11_o_i,
	input wire logic [7:0] p11_oe_n_i,
	input wire logic [7:0] drv_i,
	output logic [7:0] p3_lvl_o,
	output logic [7:0] p10_lvl_o,
	output logic [7:0] p11_lvl_o,
	output logic [15:1] addr_seen_o
);
	// ----
	// pin levels and address capture
	// ----
	assign p3_lvl_o = (p3_oe_n_i & drv_i) | (~p3_oe_n_i & p3_o_i);
	assign p10_lvl_o = (p10_oe_n_i & drv_i) | (~p10_oe_n_i & p10_o_i);
	assign p11_lvl_o = (p11_oe_n_i & drv_i) | (~p11_oe_n_i & p11_o_i);
	assign addr_seen_o = {p3_lvl_o[6:4], p10_lvl_o, p11_lvl_o[3:0]};
endmodule : sam_ext_dev

/* test_separate_address_output_mux.sv */
// testbench for the split address output block
// assumes sam_top, sam_ext_dev and the bound checker
`timescale 1ns/10ps
module test_separate_address_output_mux
	import sam_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [11:0] per_addr_i = 12'h000;
	logic per_wr_i = 1'b0;
	logic per_rd_i = 1'b0;
	logic per_hword_i = 1'b0;
	logic [15:0] per_wdata_i = 16'h0000;
	logic [15:0] per_rdata_o;
	logic per_rvalid_o;
	logic [15:1] ext_addr_i = 15'h6B3D;
	logic emu_split_en_i = 1'b0;
	logic [3:0] expansion_mode_o;
	logic split_active_o;
	logic ext_wait_req_o;
	logic [7:0] p3_pin_i, p3_pin_o, p3_pin_oe_n_o;
	logic [7:0] p10_pin_i, p10_pin_o, p10_pin_oe_n_o;
	logic [7:0] p11_pin_i, p11_pin_o, p11_pin_oe_n_o;
	logic [7:0] drv = 8'hFE;
	logic [15:1] addr_seen;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int nb[8] = '{0, 0, 4, 8, 12, 13, 14, 15};
	sam_top dut_u (.*);
	sam_ext_dev ext_u (.p3_o_i(p3_pin_o), .p3_oe_n_i(p3_pin_oe_n_o), .p10_o_i(p10_pin_o),
		.p10_oe_n_i(p10_pin_oe_n_o), .p11_o_i(p11_pin_o), .p11_oe_n_i(p11_pin_oe_n_o),
		.drv_i(drv), .p3_lvl_o(p3_pin_i), .p10_lvl_o(p10_pin_i), .p11_lvl_o(p11_pin_i),
		.addr_seen_o(addr_seen));
	always #10 clk_sys_i = ~clk_sys_i;
	// ----
	// tasks
	// ----
	task automatic test_done();
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic hw);
		@(negedge clk_sys_i);
		per_addr_i = a;
		per_wdata_i = d;
		per_hword_i = hw;
		per_wr_i = 1'b1;
		@(negedge clk_sys_i);
		per_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [15:0] exp);
		@(negedge clk_sys_i);
		per_addr_i = a;
		per_hword_i = 1'b0;
		per_rd_i = 1'b1;
		@(negedge clk_sys_i);
		per_rd_i = 1'b0;
		chk({15'h0000, per_rvalid_o}, 16'h0001);
		chk(per_rdata_o, exp);
	endtask : rd
	task automatic pins(input logic [2:0] k);
		logic [15:1] m;
		logic [15:1] v;
		m = 15'((32'h1 << nb[k]) - 32'h1);
		v = ext_addr_i & m;
		chk({8'h00, p11_pin_o}, {12'h000, v[4:1]});
		chk({8'h00, p10_pin_o}, {8'h00, v[12:5]});
		chk({8'h00, p3_pin_o}, {9'h000, v[15:13], 4'h0});
		chk({8'h00, p11_pin_oe_n_o}, 16'h00F0);
		chk({8'h00, p3_pin_oe_n_o}, 16'h008F);
		chk({15'h0000, split_active_o}, {15'h0000, k > 3'd1});
		chk({15'h0000, ext_wait_req_o}, 16'h0000);
	endtask : pins
	// ----
	// timeout
	// ----
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			test_done();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		repeat (10) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		reset_n_i = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		rd(SAM_OFF_P10_DIR[11:0], 16'h00FF);
		rd(SAM_OFF_P11_DIR[11:0], 16'h001F);
		rd(SAM_OFF_P11_LATCH[11:0], 16'h001E);
		chk({15'h0000, ext_wait_req_o}, 16'h0001);
		wr(SAM_OFF_P3_LATCH[11:0], 16'h0000, 1'b0);
		wr(SAM_OFF_P10_LATCH[11:0], 16'h0000, 1'b0);
		wr(SAM_OFF_P11_LATCH[11:0], 16'h0000, 1'b0);
		wr(SAM_OFF_P3_DIR[11:0], 16'h008F, 1'b0);
		wr(SAM_OFF_P10_DIR[11:0], 16'h0000, 1'b0);
		wr(SAM_OFF_P11_DIR[11:0], 16'h00F0, 1'b0);
		// no other alternate function is enabled on these pins
		wr(SAM_OFF_SPLIT_MODE[11:0], 16'h00FF, 1'b0);
		rd(SAM_OFF_SPLIT_MODE[11:0], 16'h0000);
		wr(SAM_OFF_SPLIT_MODE[11:0], 16'h0000, 1'b1);
		rd(12'h100, 16'h0000);
		wr(SAM_OFF_EXP_MODE[11:0], {13'h0000, SAM_EXP_64K}, 1'b0);
		repeat (6) @(negedge clk_sys_i);
		chk({15'h0000, split_active_o}, 16'h0000);
		chk({8'h00, p10_pin_o}, 16'h0000);
		emu_split_en_i = 1'b1;
		repeat (6) @(negedge clk_sys_i);
		pins(3'd7);
		chk({addr_seen, 1'b0}, {ext_addr_i, 1'b0});
		for (int k = 0; k < 8; k++) begin
			wr(SAM_OFF_SPLIT_MODE[11:0], {8'h00, 5'h1F, k[2:0]}, 1'b0);
			wr(SAM_OFF_EXP_MODE[11:0], {13'h0000, SAM_EXP_64K}, 1'b0);
			for (int j = 0; j < 2; j++) begin
				@(negedge clk_sys_i);
				ext_addr_i = ~ext_addr_i;
				repeat (2) @(negedge clk_sys_i);
				pins(k[2:0]);
			end
		end
		wr(SAM_OFF_P10_DIR[11:0], 16'h00FF, 1'b0);
		repeat (2) @(negedge clk_sys_i);
		chk({8'h00, p10_pin_oe_n_o}, 16'h0000);
		emu_split_en_i = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		chk({8'h00, p10_pin_oe_n_o}, 16'h00FF);
		test_done();
	end
endmodule : test_separate_address_output_mux
